/* File: verilog/mode_ctrl_pkg.sv */
// constants shared by the motion co-processor mode control block
// Summary of operation
// - reset returns state and configuration to defaults
// - mode from control pin or register bit
// - mode 1: analyse, filter select per pixel
// - mode 0: no analysis, filter select zero
// - bypass still forwards active samples only
// - interlaced sd codes accepted in both modes
// - interlaced hd and generic codes in both
// - progressive codes only in bypass mode
// - vertical motion on if pin or bit
// - vertical motion signalled on filter select bus
// - edge detection on if pin or bit
// - nine edge directions encoded on filter select
// - 10-bit luma, chroma out; blanking dropped
// - latency fixed: two lines plus sixteen pixels
// - standard code is word 0 bits 4:0
// - mode bit is word 0 bit 5
// - vertical motion bit is word 1 bit 0
// - edge bit is word 1 bit 1
package mode_ctrl_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [4:0] CFG0_ADDR = 5'h00;
    localparam logic [4:0] CFG1_ADDR = 5'h01;
    localparam logic [4:0] STATUS_ADDR = 5'h04;
    localparam int STD_LSB = 0;
    localparam int STD_MSB = 4;
    localparam int MODE_BIT = 5;
    localparam int VM_BIT = 0;
    localparam int ED_BIT = 1;
    localparam int STAT_MOTION = 0;
    localparam int STAT_VM = 1;
    localparam int STAT_ED = 2;
    localparam int STAT_PASS = 3;
    localparam int STAT_STD_MOTION = 4;
    localparam int STAT_MODE = 5;
    localparam logic [4:0] STD_RESET = 5'h00;
    localparam logic MODE_RESET = 1'b0;
    localparam logic VERTICAL_MOTION_CONTROL_BIT_RESET = 1'b0;
    localparam logic ED_CTL_RESET = 1'b0;
    // ----------------------------------------
    // standard code support, one bit per code
    // ----------------------------------------
    localparam logic [31:0] MOTION_STD_MASK = 32'hD500_C055;
    localparam logic [31:0] BYPASS_STD_MASK = 32'hFFFF_F155;
    // ----------------------------------------
    // latency and analysis
    // ----------------------------------------
    localparam int LINE_DELAYS = 2;
    localparam int PIXEL_DELAY = 16;
    localparam int WINDOW_TAPS = 9;
    localparam int WINDOW_CENTRE = 4;
    localparam int OUT_PIPE = PIXEL_DELAY - 2;
    localparam int FS_PIPE = PIXEL_DELAY - WINDOW_CENTRE - 4;
    localparam logic [9:0] VM_THRESHOLD = 10'h040;
    localparam logic [3:0] FS_BYPASS = 4'h0;
    localparam logic [3:0] FS_PLAIN_VERTICAL = 4'h5;
    localparam logic [3:0] FS_VERT_MOTION = 4'hA;
endpackage

/* File: verilog/delay_if.sv */
// port bundle between the video path and a line store
`timescale 1ns/1ps
interface delay_if #(parameter int WIDTH = 21);
    logic [WIDTH-1:0] din;
    logic [WIDTH-1:0] dout;
    modport feeder (output din, input dout);
    modport store (input din, output dout);
endinterface

/* File: verilog/line_store.sv */
// fixed-length delay line built on a circular array
`timescale 1ns/1ps
module line_store #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 858
) (
    input wire logic clock,
    input wire logic reset_n,
    delay_if.store link
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 2);

    logic [WIDTH-1:0] mem [DEPTH-1];
    logic [AW-1:0] ptr;
    logic [WIDTH-1:0] dout_q;
    wire [AW-1:0] next_ptr = (ptr == LAST) ? '0 : ptr + 1'b1;

    assign link.dout = dout_q;

    always_ff @(posedge clock) begin
        mem[ptr] <= link.din;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ptr <= '0;
            dout_q <= '0;
        end else begin
            ptr <= next_ptr;
            dout_q <= mem[ptr];
        end
    end
endmodule

/* File: verilog/motion_coproc_mode_control.sv */
// mode and feature control of the motion co-processor video path
`timescale 1ns/1ps
module motion_coproc_mode_control #(
    parameter int LINE_LENGTH = 858
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic mode_pin,
    input wire logic vertical_motion_enable,
    input wire logic edge_direction_enable,
    input wire logic [9:0] luma_in,
    input wire logic [9:0] chroma_in,
    input wire logic active_in,
    output logic [9:0] luma_out,
    output logic [9:0] chroma_out,
    output logic active_out,
    output logic [3:0] filter_select_bus
);
    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    logic [4:0] video_standard_code;
    logic mode_bit;
    logic vertical_motion_control_bit;
    logic edge_direction_control_bit;

    wire wr_cfg0 = reg_write && (reg_addr == mode_ctrl_pkg::CFG0_ADDR);
    wire wr_cfg1 = reg_write && (reg_addr == mode_ctrl_pkg::CFG1_ADDR);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            video_standard_code <= mode_ctrl_pkg::STD_RESET;
            mode_bit <= mode_ctrl_pkg::MODE_RESET;
            vertical_motion_control_bit <= mode_ctrl_pkg::VERTICAL_MOTION_CONTROL_BIT_RESET;
            edge_direction_control_bit <= mode_ctrl_pkg::ED_CTL_RESET;
        end else begin
            if (wr_cfg0) begin
                video_standard_code <=
                    reg_wdata[mode_ctrl_pkg::STD_MSB:mode_ctrl_pkg::STD_LSB];
            end
            if (wr_cfg0) begin
                mode_bit <= reg_wdata[mode_ctrl_pkg::MODE_BIT];
            end
            if (wr_cfg1) begin
                vertical_motion_control_bit <= reg_wdata[mode_ctrl_pkg::VM_BIT];
            end
            if (wr_cfg1) begin
                edge_direction_control_bit <= reg_wdata[mode_ctrl_pkg::ED_BIT];
            end
        end
    end

    // ----------------------------------------
    // control pin synchronisers
    // ----------------------------------------
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {edge_direction_enable, vertical_motion_enable, mode_pin};
            pin_sync <= pin_meta;
        end
    end

    // ----------------------------------------
    // effective modes
    // ----------------------------------------
    // pin or register mode
    wire mode_on = pin_sync[0] | mode_bit;
    wire vm_on = pin_sync[1] | vertical_motion_control_bit;
    wire ed_on = pin_sync[2] | edge_direction_control_bit;
    wire std_motion_ok = mode_ctrl_pkg::MOTION_STD_MASK[video_standard_code];
    wire std_pass_ok = mode_ctrl_pkg::BYPASS_STD_MASK[video_standard_code];
    // analysis only when mode and code allow
    wire motion_on = mode_on && std_motion_ok;

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    logic [15:0] status_word;

    always_comb begin
        status_word = 16'h0000;
        status_word[mode_ctrl_pkg::STAT_MOTION] = motion_on;
        status_word[mode_ctrl_pkg::STAT_VM] = vm_on;
        status_word[mode_ctrl_pkg::STAT_ED] = ed_on;
        status_word[mode_ctrl_pkg::STAT_PASS] = std_pass_ok;
        status_word[mode_ctrl_pkg::STAT_STD_MOTION] = std_motion_ok;
        status_word[mode_ctrl_pkg::STAT_MODE] = mode_on;
    end

    wire [15:0] cfg0_word = {10'h000, mode_bit, video_standard_code};
    wire [15:0] cfg1_word = {14'h0000, edge_direction_control_bit,
                             vertical_motion_control_bit};
    wire [15:0] read_mux =
        (reg_addr == mode_ctrl_pkg::CFG0_ADDR) ? cfg0_word :
        (reg_addr == mode_ctrl_pkg::CFG1_ADDR) ? cfg1_word :
        (reg_addr == mode_ctrl_pkg::STATUS_ADDR) ? status_word : 16'h0000;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_read ? read_mux : 16'h0000;
        end
    end

    // ----------------------------------------
    // two line stores
    // ----------------------------------------
    logic [20:0] in_q;
    delay_if #(.WIDTH(21)) line1_if ();
    delay_if #(.WIDTH(21)) line2_if ();

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            in_q <= 21'h00_0000;
        end else begin
            in_q <= {active_in, chroma_in, luma_in};
        end
    end

    assign line1_if.din = in_q;
    assign line2_if.din = line1_if.dout;

    line_store #(.WIDTH(21), .DEPTH(LINE_LENGTH)) line1_store (
        .clock(clock),
        .reset_n(reset_n),
        .link(line1_if.store)
    );

    line_store #(.WIDTH(21), .DEPTH(LINE_LENGTH)) line2_store (
        .clock(clock),
        .reset_n(reset_n),
        .link(line2_if.store)
    );

    wire [20:0] line2_tap = line2_if.dout;

    // ----------------------------------------
    // analysis windows
    // ----------------------------------------
    logic [9:0] top_win [mode_ctrl_pkg::WINDOW_TAPS];
    logic [9:0] bot_win [mode_ctrl_pkg::WINDOW_TAPS];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < mode_ctrl_pkg::WINDOW_TAPS; i++) begin
                top_win[i] <= 10'h000;
                bot_win[i] <= 10'h000;
            end
        end else begin
            top_win[0] <= in_q[9:0];
            bot_win[0] <= line2_tap[9:0];
            for (int i = 1; i < mode_ctrl_pkg::WINDOW_TAPS; i++) begin
                top_win[i] <= top_win[i-1];
                bot_win[i] <= bot_win[i-1];
            end
        end
    end

    logic [9:0] dir_diff [mode_ctrl_pkg::WINDOW_TAPS];
    genvar d;
    generate
        for (d = 0; d < mode_ctrl_pkg::WINDOW_TAPS; d++) begin : g_dir
            wire [9:0] a = top_win[d];
            wire [9:0] b = bot_win[mode_ctrl_pkg::WINDOW_TAPS - 1 - d];
            assign dir_diff[d] = (a > b) ? a - b : b - a;
        end
    endgenerate

    logic [3:0] best_dir;
    logic [9:0] best_diff;

    always_comb begin
        best_dir = 4'(mode_ctrl_pkg::WINDOW_CENTRE);
        best_diff = dir_diff[mode_ctrl_pkg::WINDOW_CENTRE];
        for (int i = 0; i < mode_ctrl_pkg::WINDOW_TAPS; i++) begin
            if (dir_diff[i] < best_diff) begin
                best_diff = dir_diff[i];
                best_dir = 4'(i);
            end
        end
    end

    wire vert_moving = dir_diff[mode_ctrl_pkg::WINDOW_CENTRE] >
                       mode_ctrl_pkg::VM_THRESHOLD;

    wire [3:0] next_fs =
        (vm_on && vert_moving) ? mode_ctrl_pkg::FS_VERT_MOTION :
        ed_on ? best_dir + 4'h1 : mode_ctrl_pkg::FS_PLAIN_VERTICAL;

    // ----------------------------------------
    // alignment pipes
    // ----------------------------------------
    logic [3:0] fs_pipe [mode_ctrl_pkg::FS_PIPE + 1];
    logic [20:0] out_pipe [mode_ctrl_pkg::OUT_PIPE];

    // fourteen more pixels for video, nine for filter control
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i <= mode_ctrl_pkg::FS_PIPE; i++) begin
                fs_pipe[i] <= mode_ctrl_pkg::FS_BYPASS;
            end
            for (int i = 0; i < mode_ctrl_pkg::OUT_PIPE; i++) begin
                out_pipe[i] <= 21'h00_0000;
            end
        end else begin
            fs_pipe[0] <= next_fs;
            for (int i = 1; i <= mode_ctrl_pkg::FS_PIPE; i++) begin
                fs_pipe[i] <= fs_pipe[i-1];
            end
            out_pipe[0] <= line2_tap;
            for (int i = 1; i < mode_ctrl_pkg::OUT_PIPE; i++) begin
                out_pipe[i] <= out_pipe[i-1];
            end
        end
    end

    wire [20:0] out_tap = out_pipe[mode_ctrl_pkg::OUT_PIPE - 1];
    wire pass_sample = std_pass_ok && out_tap[20];

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            luma_out <= 10'h000;
            chroma_out <= 10'h000;
            active_out <= 1'b0;
            filter_select_bus <= mode_ctrl_pkg::FS_BYPASS;
        end else begin
            luma_out <= pass_sample ? out_tap[9:0] : 10'h000;
            chroma_out <= pass_sample ? out_tap[19:10] : 10'h000;
            active_out <= pass_sample;
            filter_select_bus <= (motion_on && pass_sample) ?
                fs_pipe[mode_ctrl_pkg::FS_PIPE] : mode_ctrl_pkg::FS_BYPASS;
        end
    end
endmodule

/* File: testbench/mode_ctrl_properties.sv */
// port assertions for the mode control block
`timescale 1ns/1ps
module mode_ctrl_checker #(
    parameter int LINE_LENGTH = 858
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic mode_pin,
    input wire logic vertical_motion_enable,
    input wire logic edge_direction_enable,
    input wire logic [9:0] luma_in,
    input wire logic [9:0] chroma_in,
    input wire logic active_in,
    input wire logic [9:0] luma_out,
    input wire logic [9:0] chroma_out,
    input wire logic active_out,
    input wire logic [3:0] filter_select_bus
);
    localparam int LAT = mode_ctrl_pkg::LINE_DELAYS * LINE_LENGTH + mode_ctrl_pkg::PIXEL_DELAY;
    logic [5:0] cfg0;
    logic [1:0] cfg1;
    logic [2:0] s1, s2;
    logic [1:0] prev_fe;
    logic [3:0] settle;
    wire logic eff = s2[0] | cfg0[5];
    wire logic vm_on = s2[1] | cfg1[0];
    wire logic ed_on = s2[2] | cfg1[1];
    wire logic mm = mode_ctrl_pkg::MOTION_STD_MASK[cfg0[4:0]];
    wire logic bm = mode_ctrl_pkg::BYPASS_STD_MASK[cfg0[4:0]];
    // shadow of the configuration words and the pin syncs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cfg0 <= 6'h00;
            cfg1 <= 2'h0;
            s1 <= 3'h0;
            s2 <= 3'h0;
            prev_fe <= 2'h0;
            settle <= 4'h0;
        end else begin
            s1 <= {edge_direction_enable, vertical_motion_enable, mode_pin};
            s2 <= s1;
            // feature enables reach the filter code through the pixel pipe
            prev_fe <= {vm_on, ed_on};
            settle <= ({vm_on, ed_on} != prev_fe) ? 4'h0 :
                      (settle == 4'hF) ? 4'hF : settle + 4'h1;
            if (reg_write && reg_addr == 5'h00) begin
                cfg0 <= reg_wdata[5:0];
            end
            if (reg_write && reg_addr == 5'h01) begin
                cfg1 <= reg_wdata[1:0];
            end
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_idle_zero: assert property (
        !active_out |-> {luma_out, chroma_out, filter_select_bus} == 24'h00_0000)
        else $error("dropped sample not zero");
    a_video_latency: assert property (
        active_out |-> {luma_out, chroma_out} == $past({luma_in, chroma_in}, LAT))
        else $error("video latency wrong");
    a_std_passes: assert property (
        bm [*4] ##0 $past(active_in, LAT) |-> active_out)
        else $error("supported sample lost");
    a_bypass_zero: assert property (
        (!eff) [*4] |-> filter_select_bus == 4'h0)
        else $error("filter select set in bypass");
    a_prog_no_filter: assert property (
        (bm && !mm) [*4] |-> filter_select_bus == 4'h0)
        else $error("progressive code processed");
    a_plain_filter: assert property (
        (eff && mm && !vm_on && !ed_on) [*4] ##0 active_out && settle == 4'hF
        |-> filter_select_bus == 4'h5)
        else $error("plain filter expected");
    a_edge_code: assert property (
        (eff && mm && !vm_on && ed_on) [*4] ##0 active_out && settle == 4'hF
        |-> filter_select_bus inside {[1:9]})
        else $error("edge code out of range");
    a_word0_read: assert property (
        reg_read && reg_addr == 5'h00 |=> reg_rdata[5:0] == cfg0)
        else $error("word 0 readback wrong");
endmodule
bind motion_coproc_mode_control mode_ctrl_checker #(.LINE_LENGTH(LINE_LENGTH)) chk (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .mode_pin(mode_pin),
    .vertical_motion_enable(vertical_motion_enable), .luma_in(luma_in),
    .edge_direction_enable(edge_direction_enable), .chroma_in(chroma_in),
    .active_in(active_in), .luma_out(luma_out), .chroma_out(chroma_out),
    .active_out(active_out), .filter_select_bus(filter_select_bus));

/* File: testbench/deinterlacer_sink.sv */
// companion de-interlacer model: counts the samples it takes
`timescale 1ns/1ps
module deinterlacer_sink (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic active,
    output logic [31:0] taken
);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            taken <= 32'h0000_0000;
        end else if (active) begin
            taken <= taken + 32'h0000_0001;
        end
    end
endmodule

/* File: testbench/motion_coproc_mode_control_tb.sv */
// self-checking bench for the mode control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
$display("[ERR] %s exp %h got %h", n, e, g); end end
module motion_coproc_mode_control_tb;
    localparam int LAT = 32;
    localparam logic [31:0] MOT_OK = 32'hD500_C055;
    localparam logic [31:0] BYP_OK = 32'hFFFF_F155;
    logic clock = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic mode_pin = 1'b0, vm_pin = 1'b0, ed_pin = 1'b0, active_in = 1'b0;
    logic feed = 1'b0, moving = 1'b0, active_out;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd;
    logic [9:0] luma_in = 10'h000, chroma_in = 10'h000, luma_out, chroma_out;
    logic [3:0] fs;
    logic [7:0] c = 8'h00;
    logic [20:0] hist [64];
    logic [31:0] taken;
    int n_errors = 0, num_checks = 0, cyc = 0, stamp = 0;
    always #25 clock = ~clock;
    motion_coproc_mode_control #(.LINE_LENGTH(8)) dut (
        .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .mode_pin(mode_pin),
        .vertical_motion_enable(vm_pin), .edge_direction_enable(ed_pin), .luma_in(luma_in),
        .chroma_in(chroma_in), .active_in(active_in), .luma_out(luma_out),
        .chroma_out(chroma_out), .active_out(active_out), .filter_select_bus(fs));
    deinterlacer_sink sink (.clock(clock), .reset_n(reset_n), .active(active_out),
        .taken(taken));
    // video stream: six active samples per line, moving or still picture
    always @(posedge clock) begin
        cyc <= cyc + 1;
        hist[cyc % 64] <= {active_in, luma_in, chroma_in};
        active_in <= feed && cyc % 8 < 6;
        luma_in <= moving ? 10'(cyc / 8 % 8 * 128) : 10'(cyc % 8 * 64);
        chroma_in <= 10'(cyc * 7);
    end
    always @(negedge clock) begin
        if (reset_n && cyc > LAT + 2 && cyc - stamp > 60) begin
            check_out(hist[(cyc - LAT) % 64]);
        end
    end
    task automatic check_out(input logic [20:0] h);
        logic ea, mot, vm;
        ea = h[20] && BYP_OK[c[4:0]];
        mot = ea && (c[5] || mode_pin) && MOT_OK[c[4:0]];
        vm = (c[6] || vm_pin) && moving;
        `CHK("active_out", ea, active_out)
        `CHK("video_out", ea ? h[19:0] : 20'h0_0000, {luma_out, chroma_out})
        if (mot && !vm && (c[7] || ed_pin)) begin
            `CHK("fs_edge", 1'b1, fs inside {[1:9]})
        end else begin
            `CHK("fs", !mot ? 4'h0 : vm ? 4'hA : 4'h5, fs)
        end
    endtask
    task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        stamp <= cyc;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask
    task automatic regs_default;
        reg_rd(5'h00, rd);
        `CHK("word0", 6'h00, rd[5:0])
        reg_rd(5'h01, rd);
        `CHK("word1", 2'h0, rd[1:0])
    endtask
    // v holds edge bit, motion bit, mode bit and standard code
    task automatic cfg(input logic [7:0] v);
        reg_wr(5'h00, {10'h000, v[5:0]});
        reg_wr(5'h01, {14'h0000, v[7:6]});
        c = v;
        repeat (66) @(posedge clock);
        status_chk();
    endtask
    // status word against the programmed code, mode and pins
    task automatic status_chk;
        logic mo, sm;
        logic [5:0] st;
        mo = c[5] || mode_pin;
        sm = MOT_OK[c[4:0]];
        st = {mo, sm, BYP_OK[c[4:0]], c[7] || ed_pin, c[6] || vm_pin, mo && sm};
        reg_rd(5'h04, rd);
        `CHK("status", st, rd[5:0])
    endtask
    task automatic pins(input logic [3:0] v);
        @(posedge clock);
        {mode_pin, vm_pin, ed_pin, moving} <= v;
        stamp <= cyc;
        repeat (66) @(posedge clock);
        status_chk();
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        regs_default();
        reg_rd(5'h1F, rd);
        `CHK("unmapped", 16'h0000, rd)
        reg_wr(5'h00, 16'h003F);
        reg_wr(5'h01, 16'h0003);
        reg_rd(5'h00, rd);
        `CHK("word0", 6'h3F, rd[5:0])
        reg_rd(5'h01, rd);
        `CHK("word1", 2'h3, rd[1:0])
        feed = 1'b1;
        for (int i = 0; i < 64; i++) begin
            if (BYP_OK[i % 32]) begin
                cfg({2'h0, 1'(i / 32), 5'(i)});
            end
        end
        cfg(8'hB8);
        cfg(8'h78);
        pins(4'b0001);
        cfg(8'h00);
        pins(4'b1101);
        pins(4'b1010);
        pins(4'b0000);
        cfg(8'hFF);
        feed = 1'b0;
        repeat (80) @(posedge clock);
        reset_n <= 1'b0;
        c = 8'h00;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        stamp <= cyc;
        regs_default();
        feed = 1'b1;
        repeat (80) @(posedge clock);
        `CHK("sink_taken", 1'b1, taken != 0)
        stop_test();
    end
endmodule
